/* File: bus_phaser_pkg.sv */
`default_nettype none
package bus_phaser_pkg;
   localparam int unsigned NUM_CS = 4;
   localparam int unsigned CS_W   = 2;
   localparam int unsigned ADDR_W = 24;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned CNT_W  = 5;

   // ************************************************************
   // phase of the external bus cycle
   // ************************************************************
   typedef enum logic [2:0] {
      PH_IDLE, PH_AB, PH_C, PH_D, PH_E, PH_F
   } phase_e;

   // ************************************************************
   // chip_select_timing_config: one per chip select
   // ************************************************************
   typedef struct packed {
      logic             setup_long;  // address setup 1 (0) or 2 (1) periods
      logic [1:0]       setup_ext;   // extra setup periods on window change
      logic [1:0]       cmd_delay;   // 0..3 periods
      logic             data_setup;  // 0..1 period
      logic [CNT_W-1:0] access_len;  // access periods minus one, 1..32
      logic [1:0]       hold_len;    // 0..3 periods
   } timing_cfg_s;

   typedef struct packed {
      logic              write;
      logic              win_change;
      logic              upper;
      logic [CS_W-1:0]   cs;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_s;
endpackage
`default_nettype wire

/* File: cpu_clock_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_tick (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic cpu_clock_halving_select,
   output logic      cpu_tick
);
   typedef struct packed {
      logic tick;
   } tick_state_s;

   tick_state_s st_ff;
   tick_state_s nxt_st;

   // ************************************************************
   // one tick per cpu_clock_period: every clk, or every second clk
   // ************************************************************
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.tick = cpu_clock_halving_select ? ~st_ff.tick : 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign cpu_tick = st_ff.tick;

   half_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
      cpu_clock_halving_select && st_ff.tick ##1 cpu_clock_halving_select |-> !st_ff.tick)
      else $error("halved cpu clock ticked twice in a row");
   full_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) && !$past(cpu_clock_halving_select) && !$past(cpu_clock_halving_select, 2)
      |-> st_ff.tick)
      else $error("undivided cpu clock missed a tick");
endmodule
`default_nettype wire

/* File: external_bus_cycle_phaser.sv */
`timescale 1ns/1ps
`default_nettype none
module external_bus_cycle_phaser (
   input  wire logic                                     clk,
   input  wire logic                                     rst_n,
   input  wire logic                                     cpu_clock_halving_select,
   input  wire logic                                     mux_mode,
   input  wire bus_phaser_pkg::timing_cfg_s [bus_phaser_pkg::NUM_CS-1:0] chip_select_timing_config,
   input  wire logic                                     req_valid,
   input  wire bus_phaser_pkg::bus_req_s                 req,
   input  wire logic [bus_phaser_pkg::DATA_W-1:0]        data_in,
   output logic                                          busy,
   output logic                                          done,
   output logic [bus_phaser_pkg::DATA_W-1:0]             rdata,
   output logic [bus_phaser_pkg::ADDR_W-1:0]             addr_out,
   output logic [bus_phaser_pkg::DATA_W-1:0]             data_out,
   output logic                                          data_oe,
   output logic                                          ale,
   output logic                                          rd_n,
   output logic                                          wr_n,
   output logic                                          upper_byte_select_n,
   output logic [bus_phaser_pkg::NUM_CS-1:0]             cs_n
);
   import bus_phaser_pkg::*;

   typedef struct packed {
      phase_e              phase;
      logic [CNT_W-1:0]    cnt;
      timing_cfg_s         cfg;
      logic                mux;
      bus_req_s            rq;
      logic [DATA_W-1:0]   rdata;
      logic                busy;
      logic                done;
      logic [DATA_W-1:0]   data_out;
      logic                data_oe;
      logic                ale;
      logic                rd_n;
      logic                wr_n;
      logic                ube_n;
      logic [NUM_CS-1:0]   cs_n;
   } phaser_state_s;

   phaser_state_s st_ff;
   phaser_state_s nxt_st;
   logic          cpu_tick;
   logic          phase_end;

   cpu_clock_tick u_tick (
      .clk                      (clk),
      .rst_n                    (rst_n),
      .cpu_clock_halving_select (cpu_clock_halving_select),
      .cpu_tick                 (cpu_tick)
   );

   // ************************************************************
   // phase sequencing helpers
   // ************************************************************
   function automatic phase_e next_phase(input phase_e ph, input timing_cfg_s c);
      phase_e r;
      r = PH_IDLE;
      unique case (ph)
         PH_IDLE: r = PH_AB;
         PH_AB: begin
            if (c.cmd_delay != 2'h0) begin
               r = PH_C;
            end else if (c.data_setup) begin
               r = PH_D;
            end else begin
               r = PH_E;
            end
         end
         PH_C:    r = c.data_setup ? PH_D : PH_E;
         PH_D:    r = PH_E;
         PH_E:    r = (c.hold_len != 2'h0) ? PH_F : PH_IDLE;
         PH_F:    r = PH_IDLE;
      endcase
      return r;
   endfunction

   // counter load is the phase length minus one
   function automatic logic [CNT_W-1:0] phase_load(input phase_e ph, input timing_cfg_s c,
                                                   input logic win);
      logic [CNT_W-1:0] r;
      r = '0;
      unique case (ph)
         PH_IDLE: r = '0;
         PH_AB:   r = CNT_W'(c.setup_long) + (win ? CNT_W'(c.setup_ext) : '0);
         PH_C:    r = CNT_W'(c.cmd_delay - 2'h1);
         PH_D:    r = '0;
         PH_E:    r = c.access_len;
         PH_F:    r = CNT_W'(c.hold_len - 2'h1);
      endcase
      return r;
   endfunction

   assign phase_end = cpu_tick && (st_ff.cnt == '0);

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      phase_e      ph;
      timing_cfg_s c;
      ph     = st_ff.phase;
      c      = st_ff.cfg;
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      if (st_ff.phase == PH_IDLE) begin
         if (req_valid && cpu_tick) begin
            c          = chip_select_timing_config[req.cs];
            nxt_st.cfg = c;
            nxt_st.rq  = req;
            nxt_st.mux = mux_mode;
            ph         = PH_AB;
            nxt_st.cnt = phase_load(PH_AB, c, req.win_change);
         end
      end else if (cpu_tick) begin
         if (st_ff.cnt == '0) begin
            ph         = next_phase(st_ff.phase, c);
            nxt_st.cnt = phase_load(ph, c, st_ff.rq.win_change);
            if (st_ff.phase == PH_E && !st_ff.rq.write) begin
               nxt_st.rdata = data_in;
            end
            if (ph == PH_IDLE) begin
               nxt_st.done = 1'b1;
            end
         end else begin
            nxt_st.cnt = st_ff.cnt - CNT_W'(1);
         end
      end
      nxt_st.phase = ph;
      // pin levels follow the phase being entered
      nxt_st.busy  = (ph != PH_IDLE);
      nxt_st.ale   = (ph == PH_AB);
      nxt_st.rd_n  = !(ph == PH_E && !nxt_st.rq.write);
      nxt_st.wr_n  = !(ph == PH_E && nxt_st.rq.write);
      nxt_st.ube_n = !(ph != PH_IDLE && nxt_st.rq.upper);
      nxt_st.cs_n  = '1;
      if (ph != PH_IDLE) begin
         nxt_st.cs_n[nxt_st.rq.cs] = 1'b0;
      end
      nxt_st.data_oe  = 1'b0;
      nxt_st.data_out = nxt_st.rq.wdata;
      if (ph == PH_AB && nxt_st.mux) begin
         nxt_st.data_oe  = 1'b1;
         nxt_st.data_out = nxt_st.rq.addr[DATA_W-1:0];
      end else if (nxt_st.rq.write && (ph == PH_D || ph == PH_E || ph == PH_F)) begin
         nxt_st.data_oe = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff       <= '0;
         st_ff.rd_n  <= 1'b1;
         st_ff.wr_n  <= 1'b1;
         st_ff.ube_n <= 1'b1;
         st_ff.cs_n  <= '1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign busy                = st_ff.busy;
   assign done                = st_ff.done;
   assign rdata               = st_ff.rdata;
   assign addr_out            = st_ff.rq.addr;
   assign data_out            = st_ff.data_out;
   assign data_oe             = st_ff.data_oe;
   assign ale                 = st_ff.ale;
   assign rd_n                = st_ff.rd_n;
   assign wr_n                = st_ff.wr_n;
   assign upper_byte_select_n = st_ff.ube_n;
   assign cs_n                = st_ff.cs_n;

   // ************************************************************
   // checks
   // ************************************************************
   setup_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_ff.phase == PH_AB ##1 st_ff.phase != PH_AB) |-> st_ff.phase inside {PH_C, PH_D, PH_E})
      else $error("setup phase left to a wrong phase");
   cfg_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.busy && nxt_st.busy |=> $stable(st_ff.cfg))
      else $error("timing config changed inside a cycle");
   tick_only_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.phase != PH_IDLE && !cpu_tick |=> $stable(st_ff.phase) && $stable(st_ff.cnt))
      else $error("phase moved without a cpu tick");
   setup_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.phase == PH_AB |-> st_ff.cnt <= (st_ff.rq.win_change ? 5'h04 : 5'h01))
      else $error("setup phase too long");
   access_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_ff.phase != PH_E ##1 st_ff.phase == PH_E) |-> st_ff.cnt == st_ff.cfg.access_len)
      else $error("access phase length wrong");
   data_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.phase == PH_D |-> st_ff.cnt == 5'h00 && st_ff.cfg.data_setup)
      else $error("data setup phase wrong");
   hold_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_ff.phase == PH_E ##1 st_ff.phase == PH_F) |-> st_ff.cnt == 5'(st_ff.cfg.hold_len - 2'h1))
      else $error("hold phase length wrong");
   read_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.phase == PH_E && !st_ff.rq.write && phase_end
      |=> st_ff.rd_n && st_ff.rdata == $past(data_in))
      else $error("read data not captured at strobe end");
   no_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.phase inside {PH_AB, PH_C, PH_D} && phase_end |=> st_ff.phase != PH_IDLE)
      else $error("idle gap inside a bus cycle");

   write_cycle_c: cover property (@(posedge clk) disable iff (!rst_n)
      st_ff.phase == PH_D && st_ff.rq.write ##[1:200] st_ff.phase == PH_F);
   read_cycle_c: cover property (@(posedge clk) disable iff (!rst_n)
      st_ff.phase == PH_E && !st_ff.rq.write ##[1:200] st_ff.done);
   long_setup_c: cover property (@(posedge clk) disable iff (!rst_n)
      st_ff.phase == PH_AB && st_ff.cnt == 5'h04);
endmodule
`default_nettype wire

/* File: ext_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model
   import bus_phaser_pkg::*;
(
   input  wire logic              clk,
   input  wire logic [ADDR_W-1:0] addr_out,
   input  wire logic              rd_n,
   input  wire logic [NUM_CS-1:0] cs_n,
   output logic      [DATA_W-1:0] data_in
);
   logic [DATA_W-1:0] last = '0;
   logic              sel;

   assign sel = !rd_n && !(&cs_n);
   always @(posedge clk) begin
      if (sel) last <= addr_out[15:0] ^ 16'h5a3c;
   end
   // released bus shows the inverse of the last word, never a stale copy
   assign data_in = sel ? (addr_out[15:0] ^ 16'h5a3c) : ~last;
endmodule
`default_nettype wire

/* File: external_bus_cycle_phaser_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module external_bus_cycle_phaser_tb_top;
   import bus_phaser_pkg::*;
   logic                     clk, rst_n, halve, mux_mode, req_valid;
   timing_cfg_s [NUM_CS-1:0] cfg;
   bus_req_s                 req;
   logic [DATA_W-1:0]        data_in, rdata, data_out;
   logic [ADDR_W-1:0]        addr_out;
   logic                     busy, done, data_oe, ale, rd_n, wr_n, ube_n;
   logic [NUM_CS-1:0]        cs_n;
   int                       error_cnt = 0, n_tests = 0, cycles = 0, seed = 56594;

   // ****************************************************
   // design and far side
   // ****************************************************
   external_bus_cycle_phaser u_dut (.clk(clk), .rst_n(rst_n),
      .cpu_clock_halving_select(halve), .mux_mode(mux_mode),
      .chip_select_timing_config(cfg), .req_valid(req_valid), .req(req),
      .data_in(data_in), .busy(busy), .done(done), .rdata(rdata),
      .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe), .ale(ale),
      .rd_n(rd_n), .wr_n(wr_n), .upper_byte_select_n(ube_n), .cs_n(cs_n));
   ext_mem_model u_mem (.clk(clk), .addr_out(addr_out), .rd_n(rd_n), .cs_n(cs_n),
      .data_in(data_in));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ****************************************************
   // checking and closing
   // ****************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   // ****************************************************
   // one bus cycle against the reference count model
   // ****************************************************
   task automatic run_cycle(input logic fixmax);
      logic [31:0]       rv;
      bus_req_s          r;
      timing_cfg_s       c;
      logic [NUM_CS-1:0] exp_cs;
      int                p, ab, e, tot, nb, na, ng, nrw, nf, k;
      for (int i = 0; i < NUM_CS; i++) begin
         rv = $random(seed);
         cfg[i] = timing_cfg_s'(rv[12:0]);
      end
      rv = $random(seed);
      r.write = rv[0];
      r.win_change = rv[1] | fixmax;
      r.upper = rv[2];
      r.cs = rv[4:3];
      mux_mode = rv[5];
      r.addr = rv[31:8];
      rv = $random(seed);
      r.wdata = rv[15:0];
      if (fixmax) cfg[r.cs] = '1;
      c = cfg[r.cs];
      p = halve ? 2 : 1;
      ab = 1 + c.setup_long + (r.win_change ? c.setup_ext : 0);
      e = c.access_len + 1;
      tot = ab + c.cmd_delay + c.data_setup + e + c.hold_len;
      exp_cs = ~(NUM_CS'(1) << r.cs);
      req = r;
      req_valid = 1'b1;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (busy !== 1'b1 && k < 8);
      req_valid = 1'b0;
      check(cs_n, exp_cs);
      check(addr_out, r.addr);
      check(ube_n, !r.upper);
      if (mux_mode) check(data_out, r.addr[15:0]);
      nb = 0;
      na = 0;
      ng = 0;
      nrw = 0;
      nf = 0;
      while (done !== 1'b1 && nb < 300) begin
         nb += busy;
         na += ale;
         if (!(r.write ? wr_n : rd_n)) begin
            nrw++;
            if (nrw == 1) begin
               check(data_oe, r.write);
               if (r.write) check(data_out, r.wdata);
            end
         end else if (busy && !ale && nrw == 0) begin
            ng++;
         end else if (busy && nrw > 0) begin
            nf += r.write ? data_oe : 1'b1;
         end
         @(negedge clk);
      end
      check(nb, tot * p);
      check(na, ab * p);
      check(ng, (c.cmd_delay + c.data_setup) * p);
      check(nrw, e * p);
      check(nf, c.hold_len * p);
      check(cs_n, {NUM_CS{1'b1}});
      if (!r.write) check(rdata, r.addr[15:0] ^ 16'h5a3c);
   endtask

   // ****************************************************
   // main sequence
   // ****************************************************
   initial begin
      rst_n = 1'b0;
      halve = 1'b0;
      mux_mode = 1'b0;
      req_valid = 1'b0;
      req = '0;
      cfg = '0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 80; i++) begin
         if (i == 40) halve = 1'b1;
         run_cycle(i % 20 == 0);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
